// ---- dv/miwc_props.sv ----
// port-level checks for the interrupt and wake controller
`timescale 1ns/1ps
`default_nettype none
module miwc_props (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [7:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic stop_mode_in,
	input wire logic clock_running_in,
	input wire logic irq_req_out,
	input wire logic [15:0] irq_vector_out,
	input wire logic wake_req_out,
	input wire logic osc_restart_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	// a taken request is answered on the very next cycle
	bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus answer late");
	rdata_hold_a: assert property (!$past(avs_read_in) |-> $stable(avs_readdata_out))
		else $error("read data moved");
	vec_none_a: assert property (!irq_req_out |-> irq_vector_out == 16'h0000)
		else $error("vector without request");
	vec_grid_a: assert property (irq_req_out |-> irq_vector_out[2:0] == 3'h3
		&& irq_vector_out <= 16'h0073) else $error("vector off grid");
	osc_wake_a: assert property (osc_restart_out == wake_req_out)
		else $error("oscillator restart differs");
	wake_stop_a: assert property ($rose(wake_req_out) |-> $past(stop_mode_in))
		else $error("wake outside stop");
	wake_clear_a: assert property (wake_req_out && clock_running_in && !stop_mode_in
		|=> !wake_req_out) else $error("wake not cleared");
	wake_hold_a: assert property (wake_req_out && !(clock_running_in && !stop_mode_in)
		|=> wake_req_out) else $error("wake dropped early");
	cover property (avs_write_in && !avs_waitrequest_out);
	cover property ($rose(irq_req_out));
	cover property ($rose(wake_req_out));
endmodule : miwc_props
bind miwc_top miwc_props u_props (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.stop_mode_in(stop_mode_in), .clock_running_in(clock_running_in),
	.irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out),
	.wake_req_out(wake_req_out), .osc_restart_out(osc_restart_out));
`default_nettype wire

// ---- dv/miwc_src_model.sv ----
// peripheral interrupt sources on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module miwc_src_model (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [5:0] own_in,
	input wire logic [11:0] shared_in,
	output logic [5:0] own_flag_out,
	output logic [6:0] ext_line_flag_out
);
	logic [5:0] line_nxt;
	// two peripherals share each of six outside lines, so the line is their or; line5 is tied low
	assign line_nxt = shared_in[5:0] | shared_in[11:6];
	// flags stay in the peripheral until it clears them itself
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			own_flag_out <= 6'h0;
			ext_line_flag_out <= 7'h0;
		end
		else
		begin
			own_flag_out <= own_in;
			ext_line_flag_out <= {line_nxt[5:3], 1'b0, line_nxt[2:0]};
		end
	end
endmodule : miwc_src_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the interrupt and wake controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk_in = 0, rstn_in = 0, rd_s = 0, wr_s = 0, i2c_set = 0, stop = 0, run = 1;
	logic [7:0] addr = 0, wdata = 0, pins = 0, q, v, rdata;
	logic [5:0] own = 0, own_f;
	logic [11:0] shared = 0;
	logic [6:0] ext_f;
	logic wait_s, irq, high, wake, osc;
	logic [15:0] vec;
	logic [14:0] req, pr, en;
	logic [15:0] rv [7] = '{16'h9100, 16'h9fff, 16'ha800, 16'hb800, 16'he800, 16'hf800, 16'h0000};
	int n_errors = 0, checks_done = 0, cycles = 0;
	always #50 core_clk_in = ~core_clk_in;
	// hang guard
	always @(posedge core_clk_in)
	begin
		if (++cycles == 30000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	miwc_src_model src (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .own_in(own),
		.shared_in(shared), .own_flag_out(own_f), .ext_line_flag_out(ext_f));
	miwc_top dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .avs_address_in(addr),
		.avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_s), .timer0_flag_in(own_f[0]),
		.timer1_flag_in(own_f[1]), .timer2_flag_in(own_f[2]), .uart1_flag_in(own_f[3]),
		.uart2_flag_in(own_f[4]), .watchdog_flag_in(own_f[5]), .i2c_master_set_in(i2c_set),
		.ext_line_flag_in(ext_f), .gpio_pin_in(pins), .stop_mode_in(stop),
		.clock_running_in(run), .irq_req_out(irq), .irq_high_out(high),
		.irq_vector_out(vec), .wake_req_out(wake), .osc_restart_out(osc));
	// winner: high level first, then natural order
	function automatic logic [17:0] exp_irq(input logic [14:0] r, input logic [14:0] p);
		for (int h = 1; h >= 0; h--)
			for (int i = 0; i < 15; i++)
				if (r[i] && p[i] == h[0])
					return {1'b1, h[0], 16'h0003 + 16'(i * 8)};
		return 18'h0;
	endfunction : exp_irq
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one avalon transfer; held until waitrequest is seen low, hang guard ends a stuck wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= w;
		rd_s <= !w;
		do @(posedge core_clk_in); while (wait_s !== 1'b0);
		q = rdata;
		wr_s <= 0;
		rd_s <= 0;
		@(posedge core_clk_in);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(0, a, 0);
		chk(q, e);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		void'($urandom(32'hf25c_f847));
		tick(4);
		rstn_in <= 1;
		tick(1);
		foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
		bus(1, 8'h00, 8'h5a);
		rd(8'h00, 8'h00);
		foreach (rv[i])
			if (i >= 2 && i <= 5)
			begin
				v = 8'($urandom) & (i == 3 ? 8'h7f : 8'hff);
				bus(1, rv[i][15:8], v);
				rd(rv[i][15:8], v);
			end
		$display("test registers done");
		shared <= 12'($urandom);
		tick(3);
		v = {ext_f[6:4], 1'b0, ext_f[2:0], 1'b0};
		rd(8'h91, v);
		bus(1, 8'h91, 8'hfe);
		rd(8'h91, v);
		i2c_set <= 1;
		tick(1);
		i2c_set <= 0;
		tick(20);
		rd(8'h91, v | 8'h01);
		bus(1, 8'h91, 8'h00);
		rd(8'h91, v);
		$display("test flags done");
		bus(1, 8'h9f, 8'h00);
		rd(8'h9f, 8'hff);
		bus(1, 8'hc9, 8'haa);
		bus(1, 8'hc9, 8'h55);
		rd(8'hc9, 8'h01);
		tick(240);
		bus(1, 8'h9f, 8'h0f);
		tick(20);
		bus(1, 8'h9f, 8'hff);
		rd(8'h9f, 8'h0f);
		rd(8'hc9, 8'h00);
		bus(1, 8'hc9, 8'haa);
		bus(1, 8'hc9, 8'h55);
		bus(1, 8'h9f, 8'hfe);
		bus(1, 8'hc9, 8'h00);
		bus(1, 8'h9f, 8'hff);
		rd(8'h9f, 8'hfe);
		$display("test window done");
		shared <= 0;
		// interrupts off: the wake path must not need them
		bus(1, 8'ha8, 8'h00);
		bus(1, 8'hd0, 8'h02);
		bus(1, 8'hd1, 8'hff);
		bus(1, 8'hd2, 8'h00);
		stop <= 1;
		run <= 0;
		pins <= 8'h01;
		tick(3);
		chk(wake, 0);
		pins <= 8'h03;
		tick(4);
		chk({irq, wake, osc}, 3'b011);
		stop <= 0;
		run <= 1;
		tick(2);
		chk(wake, 0);
		stop <= 1;
		shared <= 12'h001;
		tick(3);
		chk(wake, 1);
		stop <= 0;
		tick(2);
		stop <= 1;
		tick(3);
		chk(wake, 0);
		stop <= 0;
		rd(8'hd3, 8'h03);
		bus(1, 8'hd3, 8'h00);
		bus(1, 8'hd1, 8'h00);
		bus(1, 8'hd2, 8'h01);
		pins <= 8'h00;
		tick(3);
		rd(8'hd3, 8'h01);
		bus(1, 8'hd3, 8'h00);
		$display("test wake done");
		for (int k = 0; k < 24; k++)
		begin
			own <= 6'($urandom);
			shared <= 12'($urandom);
			pr = 15'($urandom);
			en = 15'($urandom);
			v[0] = 1'($urandom);
			bus(1, 8'ha8, {v[0], en[6:0]});
			bus(1, 8'he8, en[14:7]);
			bus(1, 8'hb8, {1'b0, pr[6:0]});
			bus(1, 8'hf8, pr[14:7]);
			tick(3);
			// source order: lines 8..6, wdog, lines 4..2, i2c, uart2, t2, uart1, t1, grp1, t0, grp0
			req = {ext_f[6:4], own_f[5], ext_f[2:0], 1'b0, own_f[4], own_f[2], own_f[3], own_f[1],
				1'b0, own_f[0], 1'b0};
			chk({irq, high, vec}, exp_irq(v[0] ? req & en : 15'h0, pr));
		end
		$display("test priority done");
		rstn_in <= 0;
		tick(2);
		rstn_in <= 1;
		tick(1);
		rd(8'h9f, 8'hff);
		$display("test reset done");
		print_verdict();
	end
endmodule : tb
`default_nettype wire

// ---- hdl/miwc_pkg.sv ----
// types for the interrupt and wake controller
package miwc_pkg;
	typedef enum logic [2:0]
	{
		MIWC_UL_IDLE = 3'b001,
		MIWC_UL_KEY1 = 3'b010,
		MIWC_UL_OPEN = 3'b100
	} miwc_unlock_t;
	typedef logic [14:0] miwc_src_vec_t;
endpackage : miwc_pkg

// ---- hdl/miwc_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef MIWC_REGS_SVH
`define MIWC_REGS_SVH
`define MIWC_OFF_FLAGS_EXT 8'h91
`define MIWC_OFF_WAKE_MASK 8'h9F
`define MIWC_OFF_EN_MAIN 8'hA8
`define MIWC_OFF_PRIO_MAIN 8'hB8
`define MIWC_OFF_UNLOCK_B 8'hC9
`define MIWC_OFF_EN_EXT 8'hE8
`define MIWC_OFF_PRIO_EXT 8'hF8
`define MIWC_OFF_GPIO_ROUTE 8'hD0
`define MIWC_OFF_GPIO_RISE 8'hD1
`define MIWC_OFF_GPIO_FALL 8'hD2
`define MIWC_OFF_GPIO_PEND 8'hD3
`define MIWC_OFF_VECTOR 8'hD4
`define MIWC_OFF_STATUS 8'hD5
`define MIWC_BIT_GLOBAL_EN 7
`define MIWC_BIT_I2C_FLAG 0
`define MIWC_EXT_LINE_MASK 8'hEE
`define MIWC_RST_ZERO 8'h00
`define MIWC_RST_WAKE_MASK 8'hFF
`define MIWC_UNLOCK_KEY1 8'hAA
`define MIWC_UNLOCK_KEY2 8'h55
`define MIWC_UNLOCK_CLOSE 8'h00
`define MIWC_WINDOW_CYCLES 9'd256
`define MIWC_VEC_BASE 16'h0003
`define MIWC_VEC_STEP 16'h0008
`endif

// ---- hdl/miwc_top.sv ----
// interrupt enable, priority, flag collection and stop-mode wake control
// Summary of operation
// - global enable bit gates every forwarded request
// - main enable register holds seven source enables
// - extended enable register holds eight source enables
// - each source priority bit, one means high
// - main priority register mirrors main enable layout
// - extended priority register mirrors extended enable layout
// - extended flag register shows live line flags
// - writes to line flag bits are ignored
// - i2c flag set by hardware, software clears
// - shared lines, software finds real source
// - wake mask resets ones, gates wake sources
// - wake mask writes only inside timed window
// - unmasked wake restarts oscillator and clock
// - wake fires on source edge only in stop mode
// - wake path ignores interrupt enables
// - wake detection is clocked, needs core_clk_in running
// - each gpio pin routed to group zero/one
// - per pin rising, falling or both edges
// - pin edge detection also drives group wake
// - requests sampled on rising system clock edge
// - high level before low, then natural order
// - winner selects vector 0x0003 step eight
// - unlock opens 256 cycle write window
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "miwc_regs.svh"
module miwc_top
	import miwc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [7:0] avs_writedata_in,
	output logic [7:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic timer0_flag_in,
	input wire logic timer1_flag_in,
	input wire logic timer2_flag_in,
	input wire logic uart1_flag_in,
	input wire logic uart2_flag_in,
	input wire logic watchdog_flag_in,
	input wire logic i2c_master_set_in,
	input wire logic [6:0] ext_line_flag_in,
	input wire logic [7:0] gpio_pin_in,
	input wire logic stop_mode_in,
	input wire logic clock_running_in,
	output logic irq_req_out,
	output logic irq_high_out,
	output logic [15:0] irq_vector_out,
	output logic wake_req_out,
	output logic osc_restart_out
);
	// source order in natural priority, index 0 served first
	// 0 gpio0 1 t0 2 gpio1 3 t1 4 uart1 5 t2 6 uart2 7 i2c
	// 8 line2 9 line3 10 line4 11 wdog 12 line6 13 line7 14 line8
	logic [7:0] en_main_r;
	logic [7:0] en_ext_r;
	logic [7:0] prio_main_r;
	logic [7:0] prio_ext_r;
	logic [7:0] wake_mask_r;
	logic i2c_flag_r;
	logic [7:0] gpio_route_r;
	logic [7:0] gpio_rise_r;
	logic [7:0] gpio_fall_r;
	logic [7:0] gpio_prev_r;
	logic [1:0] gpio_pend_r;
	logic [14:0] req_samp_r;
	logic [7:0] wake_prev_r;
	logic wake_r;
	logic [8:0] win_cnt_r;
	miwc_unlock_t ul_state_r;
	logic [7:0] rdata_r;
	logic wait_r;
	logic irq_r;
	logic irq_high_r;
	logic [15:0] vec_r;

	// one wait cycle per access keeps read data registered
	wire acc = (avs_read_in | avs_write_in) & wait_r;
	// a write lands only at the edge that shows waitrequest low, so it is never early
	wire wr = avs_write_in & ~wait_r;
	wire rd = avs_read_in & wait_r;
	wire [7:0] wd = avs_writedata_in;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	wire win_open = (ul_state_r == MIWC_UL_OPEN);
	wire wr_unlock = wr & hit(avs_address_in, `MIWC_OFF_UNLOCK_B);

	// per pin edge detect, routed to a group
	logic [7:0] pin_hit;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			assign pin_hit[gi] = (gpio_rise_r[gi] & gpio_pin_in[gi] & ~gpio_prev_r[gi]) |
				(gpio_fall_r[gi] & ~gpio_pin_in[gi] & gpio_prev_r[gi]);
		end
	endgenerate
	wire grp1_hit = |(pin_hit & gpio_route_r);
	wire grp0_hit = |(pin_hit & ~gpio_route_r);

	// raw flags in source order
	wire [14:0] raw_flag = {ext_line_flag_in[6:4], watchdog_flag_in, ext_line_flag_in[2:0],
		i2c_flag_r, uart2_flag_in, timer2_flag_in, uart1_flag_in, timer1_flag_in,
		gpio_pend_r[1], timer0_flag_in, gpio_pend_r[0]};
	// timer, uart, watchdog and line flags come from peripherals; clearing there is the peripheral's job
	wire [14:0] src_en = {en_ext_r[7:5], en_ext_r[4], en_ext_r[3:1], en_ext_r[0],
		en_main_r[6:0]};
	wire [14:0] src_prio = {prio_ext_r[7:5], prio_ext_r[4], prio_ext_r[3:1], prio_ext_r[0],
		prio_main_r[6:0]};
	wire [14:0] gated = raw_flag & src_en & {15{en_main_r[`MIWC_BIT_GLOBAL_EN]}};

	// fixed order search, lowest index wins
	function automatic logic [3:0] first_set(input logic [14:0] v);
		first_set = 4'hF;
		for (int i = 14; i >= 0; i--)
		begin
			if (v[i])
			begin
				first_set = 4'(i);
			end
		end
	endfunction : first_set

	wire [14:0] hi_req = req_samp_r & src_prio;
	wire use_hi = |hi_req;
	wire [3:0] win_idx = use_hi ? first_set(hi_req) : first_set(req_samp_r);
	wire [15:0] win_vec = `MIWC_VEC_BASE + 16'({win_idx, 3'b000});

	// wake edges independent of interrupt enables
	wire [7:0] wake_src = {ext_line_flag_in[6:4], ext_line_flag_in[2:0], grp1_hit, grp0_hit};
	// flag lines are edge detected; pin groups already are edges
	wire [7:0] wake_edge = {wake_src[7:2] & ~wake_prev_r[7:2], wake_src[1:0]};
	wire wake_any = |(wake_edge & wake_mask_r);

	// read mux
	wire [7:0] flags_rd = {ext_line_flag_in[6:4], 1'b0, ext_line_flag_in[2:0], i2c_flag_r};
	wire [7:0] status_rd = {4'h0, wake_r, win_open, irq_high_r, irq_r};
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = 8'h00;
		case (avs_address_in)
			`MIWC_OFF_FLAGS_EXT: rd_mux = flags_rd;
			`MIWC_OFF_WAKE_MASK: rd_mux = wake_mask_r;
			`MIWC_OFF_EN_MAIN: rd_mux = en_main_r;
			`MIWC_OFF_PRIO_MAIN: rd_mux = {1'b0, prio_main_r[6:0]};
			`MIWC_OFF_UNLOCK_B: rd_mux = {7'h00, win_open};
			`MIWC_OFF_EN_EXT: rd_mux = en_ext_r;
			`MIWC_OFF_PRIO_EXT: rd_mux = prio_ext_r;
			`MIWC_OFF_GPIO_ROUTE: rd_mux = gpio_route_r;
			`MIWC_OFF_GPIO_RISE: rd_mux = gpio_rise_r;
			`MIWC_OFF_GPIO_FALL: rd_mux = gpio_fall_r;
			`MIWC_OFF_GPIO_PEND: rd_mux = {6'h00, gpio_pend_r};
			`MIWC_OFF_VECTOR: rd_mux = vec_r[7:0];
			`MIWC_OFF_STATUS: rd_mux = status_rd;
			default: rd_mux = 8'h00;
		endcase
	end

	// bus handshake: waitrequest drops for one cycle per access
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wait_r <= 1'b1;
			rdata_r <= `MIWC_RST_ZERO;
		end
		else
		begin
			wait_r <= ~acc;
			rdata_r <= rd ? rd_mux : rdata_r;
		end
	end

	// plain control registers
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			en_main_r <= `MIWC_RST_ZERO;
			en_ext_r <= `MIWC_RST_ZERO;
			prio_main_r <= `MIWC_RST_ZERO;
			prio_ext_r <= `MIWC_RST_ZERO;
			gpio_route_r <= `MIWC_RST_ZERO;
			gpio_rise_r <= `MIWC_RST_ZERO;
			gpio_fall_r <= `MIWC_RST_ZERO;
		end
		else if (wr)
		begin
			if (hit(avs_address_in, `MIWC_OFF_EN_MAIN)) en_main_r <= wd;
			if (hit(avs_address_in, `MIWC_OFF_EN_EXT)) en_ext_r <= wd;
			if (hit(avs_address_in, `MIWC_OFF_PRIO_MAIN)) prio_main_r <= {1'b0, wd[6:0]};
			if (hit(avs_address_in, `MIWC_OFF_PRIO_EXT)) prio_ext_r <= wd;
			if (hit(avs_address_in, `MIWC_OFF_GPIO_ROUTE)) gpio_route_r <= wd;
			if (hit(avs_address_in, `MIWC_OFF_GPIO_RISE)) gpio_rise_r <= wd;
			if (hit(avs_address_in, `MIWC_OFF_GPIO_FALL)) gpio_fall_r <= wd;
		end
	end

	// wake mask: only inside the timed window
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			wake_mask_r <= `MIWC_RST_WAKE_MASK;
		else if (wr && hit(avs_address_in, `MIWC_OFF_WAKE_MASK) && win_open)
			wake_mask_r <= wd;
	end

	// i2c flag: set wins over a clearing write; line bits are not stored
	wire i2c_clr = wr & hit(avs_address_in, `MIWC_OFF_FLAGS_EXT) & ~wd[`MIWC_BIT_I2C_FLAG];
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			i2c_flag_r <= 1'b0;
		else if (i2c_master_set_in)
			i2c_flag_r <= 1'b1;
		else if (i2c_clr)
			i2c_flag_r <= 1'b0;
	end

	// gpio group pending flags, written zero clears, edge wins
	wire pend_wr = wr & hit(avs_address_in, `MIWC_OFF_GPIO_PEND);
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			gpio_prev_r <= `MIWC_RST_ZERO;
			gpio_pend_r <= 2'b00;
		end
		else
		begin
			gpio_prev_r <= gpio_pin_in;
			gpio_pend_r[0] <= grp0_hit | (gpio_pend_r[0] & ~(pend_wr & ~wd[0]));
			gpio_pend_r[1] <= grp1_hit | (gpio_pend_r[1] & ~(pend_wr & ~wd[1]));
		end
	end

	// timed unlock sequence; a wrong second key aborts, a 0x00 write or the count running out closes the open window
	logic [8:0] win_cnt_nxt;
	miwc_unlock_t ul_state_nxt;
	always_comb
	begin
		ul_state_nxt = ul_state_r;
		win_cnt_nxt = win_cnt_r;
		case (ul_state_r)
			MIWC_UL_IDLE:
			begin
				if (wr_unlock && wd == `MIWC_UNLOCK_KEY1) ul_state_nxt = MIWC_UL_KEY1;
			end
			MIWC_UL_KEY1:
			begin
				if (wr_unlock && wd == `MIWC_UNLOCK_KEY2)
				begin
					ul_state_nxt = MIWC_UL_OPEN;
					win_cnt_nxt = `MIWC_WINDOW_CYCLES;
				end
				else if (wr_unlock)
					ul_state_nxt = MIWC_UL_IDLE;
			end
			MIWC_UL_OPEN:
			begin
				win_cnt_nxt = win_cnt_r - 9'd1;
				if ((wr_unlock && wd == `MIWC_UNLOCK_CLOSE) || win_cnt_r == 9'd1)
					ul_state_nxt = MIWC_UL_IDLE;
				else if (wr_unlock && wd == `MIWC_UNLOCK_KEY1)
					ul_state_nxt = MIWC_UL_OPEN;
			end
			default: ul_state_nxt = MIWC_UL_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ul_state_r <= MIWC_UL_IDLE;
			win_cnt_r <= 9'd0;
		end
		else
		begin
			ul_state_r <= ul_state_nxt;
			win_cnt_r <= win_cnt_nxt;
		end
	end

	// request sampling and resolved outputs, one flop stage each
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			req_samp_r <= 15'h0000;
			irq_r <= 1'b0;
			irq_high_r <= 1'b0;
			vec_r <= 16'h0000;
		end
		else
		begin
			req_samp_r <= gated;
			irq_r <= |req_samp_r;
			irq_high_r <= use_hi;
			vec_r <= (|req_samp_r) ? win_vec : 16'h0000;
		end
	end

	// wake latch; hold until clock confirmed running outside stop
	// limitation: the edge latch here is clocked; in silicon the same gate
	// drives an async set so it works with the clock stopped
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wake_prev_r <= `MIWC_RST_ZERO;
			wake_r <= 1'b0;
		end
		else
		begin
			wake_prev_r <= wake_src;
			if (wake_any && stop_mode_in)
				wake_r <= 1'b1;
			else if (clock_running_in && !stop_mode_in)
				wake_r <= 1'b0;
		end
	end

	assign avs_readdata_out = rdata_r;
	assign avs_waitrequest_out = wait_r;
	assign irq_req_out = irq_r;
	assign irq_high_out = irq_high_r;
	assign irq_vector_out = vec_r;
	assign wake_req_out = wake_r;
	assign osc_restart_out = wake_r;
endmodule : miwc_top
`default_nettype wire
